// File: rtl/eed_pkg.sv
// package for the echo envelope datapath: register map, reset values, coefficient carrier
// assumes one 20 MHz clock shared by the register bus, sample source and fifo writer
package eed_pkg;

   // ***********************************
   // timing
   // ***********************************
   localparam int CLK_HZ = 20_000_000;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;

   // ***********************************
   // widths and fixed-point layout
   // ***********************************
   localparam int ADC_W = 12;
   localparam int DATA_W = 16;
   localparam int ACC_W = 40;
   localparam int FRAC_W = 15;
   localparam int DEC_W = 6;

   // ***********************************
   // register map (byte addresses)
   // ***********************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DECIMATION = 8'h04;
   localparam logic [7:0] ADDR_BP_FF = 8'h08;
   localparam logic [7:0] ADDR_BP_FB1 = 8'h0C;
   localparam logic [7:0] ADDR_BP_FB2 = 8'h10;
   localparam logic [7:0] ADDR_LP_FF = 8'h14;
   localparam logic [7:0] ADDR_LP_FB = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_LOWPASS_BIT = 1;
   localparam int STATUS_COUNT_LSB = 16;

   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [DEC_W-1:0] DECIMATION_RESET = 6'h19;
   localparam logic [15:0] BP_FF_RESET = 16'h032D;
   localparam logic [15:0] BP_FB1_RESET = 16'hF4E6;
   localparam logic [15:0] BP_FB2_RESET = 16'hF9A5;
   localparam logic [15:0] LP_FF_RESET = 16'h04D7;
   localparam logic [15:0] LP_FB_RESET = 16'h7652;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {REG_CTRL, REG_DECIMATION, REG_BP_FF, REG_BP_FB1, REG_BP_FB2,
                 REG_LP_FF, REG_LP_FB, REG_STATUS, REG_NONE} eed_reg_type;

   typedef struct packed {
      logic signed [15:0] bandpass_feedforward_coef;
      logic signed [15:0] bandpass_feedback_coef_first;
      logic signed [15:0] bandpass_feedback_coef_second;
   } eed_bp_coef_type;

   // ***********************************
   // helpers
   // ***********************************
   // clip a wide accumulator into the 16-bit signed sample range
   function automatic logic signed [DATA_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
      if (v > ACC_W'(signed'(16'sh7FFF)))
         return 16'sh7FFF;
      else if (v < ACC_W'(signed'(16'sh8000)))
         return 16'sh8000;
      else
         return v[DATA_W-1:0];
   endfunction : sat16

endpackage : eed_pkg

// File: rtl/eed_bandpass.sv
// second-order band-pass section for the echo path
// assumes at most one sample every few clocks and a coefficient set held stable by software
module eed_bandpass
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire logic clear,
   input wire logic in_valid,
   input wire logic signed [15:0] in_data,
   input wire eed_pkg::eed_bp_coef_type coef,
   output logic out_valid,
   output logic signed [15:0] out_data
);

   logic signed [15:0] x1;
   logic signed [15:0] x2;
   logic signed [15:0] y2;
   logic signed [eed_pkg::ACC_W-1:0] diff;
   logic signed [eed_pkg::ACC_W-1:0] acc;
   logic signed [eed_pkg::ACC_W-1:0] next_y;

   // ***********************************
   // arithmetic
   // ***********************************
   // coefficients are deviations from the resonator 2*y1 - y2, so small q15 values keep the poles near the circle
   always_comb
   begin
      diff = eed_pkg::ACC_W'(in_data) - eed_pkg::ACC_W'(x2);
      acc = eed_pkg::ACC_W'(coef.bandpass_feedforward_coef) * diff
          + eed_pkg::ACC_W'(coef.bandpass_feedback_coef_first) * eed_pkg::ACC_W'(out_data)
          - eed_pkg::ACC_W'(coef.bandpass_feedback_coef_second) * eed_pkg::ACC_W'(y2);
      next_y = (acc >>> eed_pkg::FRAC_W) + (eed_pkg::ACC_W'(out_data) <<< 1) - eed_pkg::ACC_W'(y2);
   end

   // ***********************************
   // state
   // ***********************************
   always_ff @(posedge clk_sys)
   begin
      if (srst || (ce && clear))
      begin
         x1 <= '0;
         x2 <= '0;
         y2 <= '0;
         out_data <= '0;
      end
      else if (ce && in_valid)
      begin
         x1 <= in_data;
         x2 <= x1;
         y2 <= out_data;
         out_data <= eed_pkg::sat16(next_y);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         out_valid <= 1'b0;
      else if (ce)
         out_valid <= in_valid && !clear;
   end

endmodule : eed_bandpass

// File: rtl/eed_datapath.sv
// echo envelope datapath: band-pass, rectifier, moving peak, decimator, optional low-pass
// assumes the converter answers each sample_request with one adc_valid pulse on clk_sys
// and that the fifo writer accepts every fifo_valid pulse
//
// Contract
// - band-pass second-order iir on echo samples
// - band-pass tuned only by three coefficients
// - rectify band-pass output to magnitude
// - peak holds if larger, else takes input
// - decimation counter zero up to count
// - at count emit sample, clear peak
// - one output per count microseconds
// - optional first-order low-pass on output
// - input is 12-bit converter word
// - final sample goes to fifo writer
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
module eed_datapath
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter and fifo writer
   output logic sample_request,
   input wire logic adc_valid,
   input wire logic [11:0] adc_data,
   output logic fifo_valid,
   output logic [15:0] fifo_data
);

   // ***********************************
   // register decode
   // ***********************************
   function automatic eed_pkg::eed_reg_type decode(input logic [7:0] a);
      if (a == eed_pkg::ADDR_CTRL) return eed_pkg::REG_CTRL;
      else if (a == eed_pkg::ADDR_DECIMATION) return eed_pkg::REG_DECIMATION;
      else if (a == eed_pkg::ADDR_BP_FF) return eed_pkg::REG_BP_FF;
      else if (a == eed_pkg::ADDR_BP_FB1) return eed_pkg::REG_BP_FB1;
      else if (a == eed_pkg::ADDR_BP_FB2) return eed_pkg::REG_BP_FB2;
      else if (a == eed_pkg::ADDR_LP_FF) return eed_pkg::REG_LP_FF;
      else if (a == eed_pkg::ADDR_LP_FB) return eed_pkg::REG_LP_FB;
      else if (a == eed_pkg::ADDR_STATUS) return eed_pkg::REG_STATUS;
      else return eed_pkg::REG_NONE;
   endfunction : decode

   logic [1:0] ctrl;
   logic [eed_pkg::DEC_W-1:0] decimation;
   eed_pkg::eed_bp_coef_type bp_coef;
   logic signed [15:0] lowpass_feedforward_coef;
   logic signed [15:0] lowpass_feedback_coef;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [eed_pkg::DEC_W-1:0] dec_count;
   logic [31:0] read_word;
   eed_pkg::eed_reg_type rd_sel;
   eed_pkg::eed_reg_type wr_sel;
   logic do_write;

   assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;
   assign do_write = ce && aw_held && w_held && !s_axi_bvalid;
   assign wr_sel = decode(aw_addr);
   assign rd_sel = decode(s_axi_araddr);

   // ***********************************
   // write channel
   // ***********************************
   // address and data are caught separately, so either may arrive first
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= eed_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == eed_pkg::REG_NONE || wr_sel == eed_pkg::REG_STATUS) ?
                           eed_pkg::RESP_SLVERR : eed_pkg::RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // byte lanes 0 and 1 carry the 16-bit fields; lane 0 alone carries control and count
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl <= eed_pkg::CTRL_RESET;
         decimation <= eed_pkg::DECIMATION_RESET;
         bp_coef.bandpass_feedforward_coef <= eed_pkg::BP_FF_RESET;
         bp_coef.bandpass_feedback_coef_first <= eed_pkg::BP_FB1_RESET;
         bp_coef.bandpass_feedback_coef_second <= eed_pkg::BP_FB2_RESET;
         lowpass_feedforward_coef <= eed_pkg::LP_FF_RESET;
         lowpass_feedback_coef <= eed_pkg::LP_FB_RESET;
      end
      else if (do_write)
      begin
         if (wr_sel == eed_pkg::REG_CTRL && w_strb[0])
            ctrl <= w_data[1:0];
         else if (wr_sel == eed_pkg::REG_DECIMATION && w_strb[0])
            decimation <= w_data[eed_pkg::DEC_W-1:0];
         for (int b = 0; b < 2; b++)
         begin
            if (w_strb[b])
            begin
               if (wr_sel == eed_pkg::REG_BP_FF)
                  bp_coef.bandpass_feedforward_coef[8*b +: 8] <= w_data[8*b +: 8];
               else if (wr_sel == eed_pkg::REG_BP_FB1)
                  bp_coef.bandpass_feedback_coef_first[8*b +: 8] <= w_data[8*b +: 8];
               else if (wr_sel == eed_pkg::REG_BP_FB2)
                  bp_coef.bandpass_feedback_coef_second[8*b +: 8] <= w_data[8*b +: 8];
               else if (wr_sel == eed_pkg::REG_LP_FF)
                  lowpass_feedforward_coef[8*b +: 8] <= w_data[8*b +: 8];
               else if (wr_sel == eed_pkg::REG_LP_FB)
                  lowpass_feedback_coef[8*b +: 8] <= w_data[8*b +: 8];
            end
         end
      end
   end

   // ***********************************
   // read channel
   // ***********************************
   always_comb
   begin
      read_word = '0;
      case (rd_sel)
         eed_pkg::REG_CTRL: read_word[1:0] = ctrl;
         eed_pkg::REG_DECIMATION: read_word[eed_pkg::DEC_W-1:0] = decimation;
         eed_pkg::REG_BP_FF: read_word[15:0] = bp_coef.bandpass_feedforward_coef;
         eed_pkg::REG_BP_FB1: read_word[15:0] = bp_coef.bandpass_feedback_coef_first;
         eed_pkg::REG_BP_FB2: read_word[15:0] = bp_coef.bandpass_feedback_coef_second;
         eed_pkg::REG_LP_FF: read_word[15:0] = lowpass_feedforward_coef;
         eed_pkg::REG_LP_FB: read_word[15:0] = lowpass_feedback_coef;
         eed_pkg::REG_STATUS:
         begin
            read_word[15:0] = fifo_data;
            read_word[eed_pkg::STATUS_COUNT_LSB +: eed_pkg::DEC_W] = dec_count;
         end
         default: read_word = '0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= eed_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= (rd_sel == eed_pkg::REG_NONE) ? eed_pkg::RESP_SLVERR : eed_pkg::RESP_OKAY;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************
   // sample pacing
   // ***********************************
   localparam int PACE_W = $clog2(eed_pkg::SAMPLE_CYCLES);
   logic [PACE_W-1:0] pace;
   logic enable;
   assign enable = ctrl[eed_pkg::CTRL_ENABLE_BIT];

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pace <= '0;
         sample_request <= 1'b0;
      end
      else if (ce)
      begin
         sample_request <= 1'b0;
         if (!enable)
            pace <= '0;
         else if (pace == PACE_W'(eed_pkg::SAMPLE_CYCLES - 1))
         begin
            pace <= '0;
            sample_request <= 1'b1;
         end
         else
            pace <= pace + 1'b1;
      end
   end

   // ***********************************
   // band-pass
   // ***********************************
   logic signed [15:0] adc_signed;
   logic bp_valid;
   logic signed [15:0] bp_data;

   // converter is offset binary around mid-scale; flipping the top bit centres it on zero
   assign adc_signed = 16'(signed'({~adc_data[eed_pkg::ADC_W-1], adc_data[eed_pkg::ADC_W-2:0]}));

   eed_bandpass u_bandpass
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .clear(!enable),
      .in_valid(adc_valid && enable),
      .in_data(adc_signed),
      .coef(bp_coef),
      .out_valid(bp_valid),
      .out_data(bp_data)
   );

   // ***********************************
   // rectifier, peak, decimator
   // ***********************************
   logic [15:0] magnitude;
   logic [15:0] peak;
   logic [15:0] next_peak;
   logic dec_hit;
   logic dec_valid;
   logic [15:0] dec_data;

   // -32768 has no positive twin, so it clips to the largest magnitude
   assign magnitude = (bp_data == 16'sh8000) ? 16'h7FFF :
                      (bp_data < 0) ? 16'(-bp_data) : 16'(bp_data);
   assign next_peak = (peak > magnitude) ? peak : magnitude;
   // a count of zero behaves as one so the output never stalls
   assign dec_hit = (dec_count + 1'b1 >= decimation);

   always_ff @(posedge clk_sys)
   begin
      if (srst || (ce && !enable))
      begin
         peak <= '0;
         dec_count <= '0;
         dec_valid <= 1'b0;
         dec_data <= '0;
      end
      else if (ce)
      begin
         dec_valid <= 1'b0;
         if (bp_valid)
         begin
            if (dec_hit)
            begin
               dec_count <= '0;
               dec_valid <= 1'b1;
               dec_data <= next_peak;
               peak <= '0;
            end
            else
            begin
               dec_count <= dec_count + 1'b1;
               peak <= next_peak;
            end
         end
      end
   end

   // ***********************************
   // low-pass and output select
   // ***********************************
   logic signed [15:0] lp_prev_in;
   logic [15:0] fifo_lp;
   logic signed [eed_pkg::ACC_W-1:0] lp_acc;
   logic lowpass_on;
   assign lowpass_on = ctrl[eed_pkg::CTRL_LOWPASS_BIT];

   // y = (ff*(x + x1) + fb*y1) >> 15 gives unity gain at dc for the tabulated pairs
   always_comb
   begin
      lp_acc = eed_pkg::ACC_W'(lowpass_feedforward_coef) *
               (eed_pkg::ACC_W'(signed'({1'b0, dec_data[14:0]})) + eed_pkg::ACC_W'(lp_prev_in))
             + eed_pkg::ACC_W'(lowpass_feedback_coef) * eed_pkg::ACC_W'(signed'(fifo_lp));
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst || (ce && !enable))
      begin
         lp_prev_in <= '0;
         fifo_lp <= '0;
         fifo_valid <= 1'b0;
         fifo_data <= '0;
      end
      else if (ce)
      begin
         fifo_valid <= dec_valid;
         if (dec_valid)
         begin
            lp_prev_in <= signed'({1'b0, dec_data[14:0]});
            fifo_lp <= eed_pkg::sat16(lp_acc >>> eed_pkg::FRAC_W);
            fifo_data <= lowpass_on ? eed_pkg::sat16(lp_acc >>> eed_pkg::FRAC_W) : dec_data;
         end
      end
   end

endmodule : eed_datapath

// File: tb/eed_datapath_monitor.sv
// port checker for the echo envelope datapath
// assumes a bind onto eed_datapath and one clock domain
module eed_datapath_monitor
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_request,
   input wire logic adc_valid,
   input wire logic fifo_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // cycles since the last request; frozen with the design when ce is low
   logic [4:0] gap;
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         gap <= 5'h1F;
      else if (ce)
         gap <= sample_request ? 5'h00 : ((gap == 5'h1F) ? gap : gap + 5'h01);
   end
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   ready_freeze_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("ready high with clock enable low");
   // both halves are registered first, so the response follows two edges after they are taken
   write_answer_a: assert property (aw_w_taken |=> ##1 s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   read_unmapped_a: assert property (ar_taken and s_axi_araddr > 8'h1C |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   fifo_pulse_a: assert property (fifo_valid |=> !fifo_valid)
      else $error("output pulse too long");
   fifo_latency_a: assert property (fifo_valid |-> $past(adc_valid, 3))
      else $error("output not three cycles after a sample");
   request_gap_a: assert property (sample_request |-> gap >= 5'h13)
      else $error("sample requests closer than one microsecond");
endmodule : eed_datapath_monitor

// File: tb/eed_adc_model.sv
// converter model: answers each sample request with one sample after 1 to 3 cycles
// assumes the fifo writer side simply accepts every output pulse
module eed_adc_model
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sample_request,
   output logic adc_valid,
   output logic [11:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 32'h1F469CD9;
   int wait_n;
   initial
   begin
      adc_valid = 1'b0;
      adc_data = 12'h800;
      forever
      begin
         @(posedge clk_sys);
         if (sample_request && !srst)
         begin
            wait_n = 1 + ($unsigned($random(seed)) % 3);
            repeat (wait_n - 1) @(posedge clk_sys);
            adc_valid <= 1'b1;
            adc_data <= 12'($random(seed));
            @(posedge clk_sys);
            adc_valid <= 1'b0;
            // word no longer valid: show the inverse, not a stale copy
            adc_data <= ~adc_data;
         end
      end
   end
endmodule : eed_adc_model

// File: tb/test_eed_datapath.sv
// self-checking bench for the echo envelope datapath against an integer model
// assumes the converter model and the port checker in tb/
module test_eed_datapath;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, srst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic sample_request, adc_valid, fifo_valid, en_m, lp_m;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [11:0] adc_data;
   logic [15:0] fifo_data, bff, bf1, bf2, lff, lfb, last_out;
   logic [15:0] expq[$];
   longint x1, x2, y1, y2, lx1, ly1, pk;
   int cnt, dec_n, i, j;
   int n_fail = 0;
   int samples_checked = 0;
   // columns: count, bp ff, bp fb1, bp fb2, lp ff, lp fb, low-pass select, outputs to wait for
   logic [15:0] cfg [5][8] = '{
      '{16'h0003, 16'h032D, 16'hF4E6, 16'hF9A5, 16'h04D7, 16'h7652, 16'h0000, 16'h0004},
      '{16'h0001, 16'h0582, 16'hF2AE, 16'hF4FB, 16'h04D7, 16'h7652, 16'h0000, 16'h0006},
      '{16'h003F, 16'h03F6, 16'hF427, 16'hF815, 16'h04D7, 16'h7652, 16'h0000, 16'h0002},
      '{16'h0019, 16'h032D, 16'hF4E6, 16'hF9A5, 16'h04D7, 16'h7652, 16'h0001, 16'h0003},
      '{16'h0032, 16'h04BD, 16'hF154, 16'hF687, 16'h1F64, 16'h4138, 16'h0001, 16'h0002}};
   logic [31:0] rst_v [7] = '{32'h0, 32'h19, 32'h32D, 32'hF4E6, 32'hF9A5, 32'h4D7, 32'h7652};

   eed_datapath dut (.clk_sys, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sample_request, .adc_valid, .adc_data, .fifo_valid, .fifo_data);
   eed_adc_model adc (.clk_sys, .srst, .sample_request, .adc_valid, .adc_data);

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_fail++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clk_sys);
         if (!aw_done && s_axi_awready)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axr

   function automatic longint clip(input longint v);
      return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
   endfunction : clip

   // ***********************************
   // reference model and output compare
   // ***********************************
   always @(posedge clk_sys)
   begin : ref_step
      longint x, y, r;
      if (!srst && en_m && adc_valid)
      begin
         x = longint'(adc_data) - 2048;
         y = clip(2 * y1 - y2 + ((longint'($signed(bff)) * (x - x2) + longint'($signed(bf1)) * y1
            - longint'($signed(bf2)) * y2) >>> 15));
         x2 = x1;
         x1 = x;
         y2 = y1;
         y1 = y;
         r = (y < 0) ? ((y == -32768) ? 32767 : -y) : y;
         if (r >= pk)
            pk = r;
         if (cnt + 1 >= dec_n)
         begin
            y = clip((longint'($signed(lff)) * (pk + lx1) + longint'($signed(lfb)) * ly1) >>> 15);
            lx1 = pk;
            ly1 = y;
            expq.push_back(16'(lp_m ? y : pk));
            cnt = 0;
            pk = 0;
         end
         else
            cnt++;
      end
      if (!srst && fifo_valid)
      begin
         last_out = (expq.size() > 0) ? expq.pop_front() : ~fifo_data;
         check({16'h0, fifo_data}, {16'h0, last_out});
      end
   end

   initial
   begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      test_done();
   end

   initial
   begin
      {srst, ce, en_m, lp_m} = 4'b1100;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge clk_sys);
      srst <= 1'b0;
      for (j = 0; j < 7; j++)
      begin
         axr(8'(4 * j), rd, rr);
         check(rd, rst_v[j]);
      end
      axr(8'h20, rd, rr);
      check(rd, 32'h0);
      check({30'h0, rr}, {30'h0, eed_pkg::RESP_SLVERR});
      axw(eed_pkg::ADDR_STATUS, 32'h0, eed_pkg::RESP_SLVERR);
      for (i = 0; i < 5; i++)
      begin
         axw(eed_pkg::ADDR_CTRL, 32'h0, eed_pkg::RESP_OKAY);
         en_m = 1'b0;
         {x1, x2, y1, y2, lx1, ly1, pk, cnt} = '0;
         // pause the core while idle; also spaces the next request a microsecond off
         ce <= 1'b0;
         repeat (4) @(posedge clk_sys);
         ce <= 1'b1;
         repeat (20) @(posedge clk_sys);
         for (j = 0; j < 6; j++)
            axw(8'(4 * j + 4), {16'h0, cfg[i][j]}, eed_pkg::RESP_OKAY);
         {bff, bf1, bf2, lff, lfb} = {cfg[i][1], cfg[i][2], cfg[i][3], cfg[i][4], cfg[i][5]};
         dec_n = int'(cfg[i][0]);
         lp_m = cfg[i][6][0];
         axw(eed_pkg::ADDR_CTRL, {30'h0, lp_m, 1'b1}, eed_pkg::RESP_OKAY);
         en_m = 1'b1;
         repeat (int'(cfg[i][7])) @(posedge clk_sys iff fifo_valid);
      end
      axr(eed_pkg::ADDR_STATUS, rd, rr);
      check({16'h0, rd[15:0]}, {16'h0, last_out});
      check({26'h0, rd[21:16]}, 32'(cnt));
      check(expq.size(), 0);
      test_done();
   end
endmodule : test_eed_datapath

bind eed_datapath eed_datapath_monitor mon (.clk_sys, .srst, .ce, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_request, .adc_valid,
   .fifo_valid);
